// ===== design/serial_nor_command_decoder.v
// Command decoder and sequencer of a serial NOR flash behind its select, clock and data pins
`timescale 1ns/100ps
`default_nettype none
`include "serial_nor_map.vh"
module serial_nor_command_decoder #(
	parameter MEM_AW = 12,
	parameter [4:0] SECT_AW = 5'h0C,
	parameter [4:0] BLOCK_AW = 5'h10,
	parameter [31:0] VSL_CYC = `POWERUP_SELECT_DELAY_US * `MCLK_MHZ,
	parameter [31:0] PP_CYC = `PAGE_WRITE_TYP_US * `MCLK_MHZ,
	parameter [31:0] TW_CYC = `STATUS_LOAD_TYP_US * `MCLK_MHZ,
	parameter [31:0] SE_CYC = `SMALL_REGION_TYP_US * `MCLK_MHZ,
	parameter [31:0] BE_CYC = `BLOCK_TYP_US * `MCLK_MHZ,
	parameter [31:0] CE_CYC = `ARRAY_TYP_US * `MCLK_MHZ,
	// Identification values are arbitrary
	parameter [7:0] MAKER_ID = 8'h5A,
	parameter [7:0] TYPE_ID = 8'h21,
	parameter [7:0] CAP_ID = 8'h15,
	parameter [7:0] PART_ID = 8'h14,
	parameter [7:0] SIG_ID = 8'h14
) (
	input wire mclk_i,
	input wire reset_n_i,
	input wire cs_n_i,
	input wire sclk_i,
	input wire [3:0] io_i,
	output reg [3:0] io_o,
	output reg [3:0] io_oe_n_o
);

	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_CMD = 3'h1;
	localparam [2:0] S_ADDR = 3'h2;
	localparam [2:0] S_MODE = 3'h3;
	localparam [2:0] S_DUMMY = 3'h4;
	localparam [2:0] S_DIN = 3'h5;
	localparam [2:0] S_DOUT = 3'h6;
	localparam [2:0] S_SKIP = 3'h7;
	localparam [MEM_AW:0] FULL = {1'b1, {MEM_AW{1'b0}}};

	function [5:0] clocks_for;
		input [5:0] bits;
		input [2:0] w;
		begin
			case (w)
				`WID_X4: clocks_for = {2'b00, bits[5:2]};
				`WID_X2: clocks_for = {1'b0, bits[5:1]};
				default: clocks_for = bits;
			endcase
		end
	endfunction

	function [MEM_AW:0] region_len;
		input [4:0] lg;
		begin
			if (lg >= MEM_AW)
				region_len = FULL;
			else
				region_len = {{MEM_AW{1'b0}}, 1'b1} << lg;
		end
	endfunction

	function needs_wel;
		input [7:0] code;
		begin
			case (code)
				`OP_STATUS_LOAD, `OP_PAGE_WRITE, `OP_QUAD_PAGE_WRITE, `OP_SMALL_REGION_CLEAR,
				`OP_BLOCK_CLEAR, `OP_ARRAY_CLEAR_A, `OP_ARRAY_CLEAR_B: needs_wel = 1'b1;
				default: needs_wel = 1'b0;
			endcase
		end
	endfunction

	// Pin synchronisers: meta is read only by sync
	reg [5:0] meta;
	reg [5:0] sync;
	reg sclk_d;
	reg cs_d;
	wire cs_s = sync[5];
	wire [3:0] io_s = sync[3:0];
	wire rise = sync[4] & ~sclk_d & ~cs_s;
	wire fall = ~sync[4] & sclk_d & ~cs_s;
	wire cs_fall = ~cs_s & cs_d;
	wire cs_rise = cs_s & ~cs_d;

	always @(posedge mclk_i) begin
		if (!reset_n_i) begin
			// Serial clock idles low, so its history starts low to avoid a false edge
			meta <= 6'h2F;
			sync <= 6'h2F;
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
		end else begin
			meta <= {cs_n_i, sclk_i, io_i};
			sync <= meta;
			sclk_d <= sync[4];
			cs_d <= sync[5];
		end
	end

	reg [7:0] mem [0:(1 << MEM_AW) - 1];
	reg [2:0] state;
	reg [7:0] op;
	reg [2:0] wid;
	reg [5:0] cnt;
	reg [5:0] plen;
	reg [5:0] tot;
	reg [31:0] sh;
	reg [23:0] addr;
	reg [7:0] obuf;
	reg [3:0] ocnt;
	reg wel;
	reg busy;
	reg sleep;
	reg enh;
	reg got_byte;
	reg powered;
	reg [5:0] stat_hi;
	reg [7:0] stat_new;
	reg [31:0] timer;
	reg [MEM_AW-1:0] sw_ptr;
	reg [MEM_AW:0] sw_left;
	reg [31:0] next_sh;
	reg [7:0] fetch_byte;

	wire [MEM_AW-1:0] maddr = addr[MEM_AW-1:0];
	wire [7:0] status = {stat_hi, wel, busy};
	wire [7:0] status_init = `STATUS_RESET;
	wire [7:0] op_in = next_sh[7:0];
	wire [7:0] out_src = (ocnt == 4'h0) ? fetch_byte : obuf;
	wire [3:0] ocnt_next = ocnt + {1'b0, wid};
	wire phase_end = (cnt + 6'h01 == plen) && (state != S_DOUT) && (state != S_SKIP);
	wire [MEM_AW:0] er_len = region_len((op == `OP_BLOCK_CLEAR) ? BLOCK_AW : SECT_AW);
	wire [MEM_AW:0] er_msk = er_len - 1'b1;
	wire refuse = (busy && op_in != `OP_STATUS_FETCH) || (sleep && op_in != `OP_SLEEP_WAKE) ||
		(needs_wel(op_in) && !wel);

	always @* begin
		case (wid)
			`WID_X4: next_sh = {sh[27:0], io_s};
			`WID_X2: next_sh = {sh[29:0], io_s[1:0]};
			default: next_sh = {sh[30:0], io_s[0]};
		endcase
	end

	always @* begin
		case (op)
			`OP_IDENT_BYTES_READ: begin
				case (addr[1:0])
					2'h0: fetch_byte = MAKER_ID;
					2'h1: fetch_byte = TYPE_ID;
					default: fetch_byte = CAP_ID;
				endcase
			end
			`OP_STATUS_FETCH: fetch_byte = status;
			`OP_SLEEP_WAKE: fetch_byte = SIG_ID;
			`OP_MAKER_PART_ID_A, `OP_MAKER_PART_ID_B, `OP_MAKER_PART_ID_C:
				fetch_byte = addr[0] ? PART_ID : MAKER_ID;
			default: fetch_byte = mem[maddr];
		endcase
	end

	always @(posedge mclk_i) begin
		if (!reset_n_i) begin
			state <= S_IDLE;
			op <= `OP_NONE;
			wid <= `WID_X1;
			cnt <= 6'h00;
			plen <= `BYTE_BITS;
			tot <= 6'h00;
			sh <= 32'h00000000;
			addr <= 24'h000000;
			obuf <= 8'h00;
			ocnt <= 4'h0;
			io_o <= 4'h0;
			io_oe_n_o <= 4'hF;
			wel <= 1'b0;
			busy <= 1'b0;
			sleep <= 1'b0;
			enh <= 1'b0;
			got_byte <= 1'b0;
			powered <= 1'b0;
			stat_hi <= status_init[7:2];
			stat_new <= 8'h00;
			timer <= VSL_CYC;
			sw_ptr <= {MEM_AW{1'b0}};
			sw_left <= FULL;
		end else begin
			// Erase walks the region one byte per clock while the timer runs; busy clears once both are done
			if (sw_left != {(MEM_AW + 1){1'b0}}) begin
				mem[sw_ptr] <= `ERASED_BYTE;
				sw_ptr <= sw_ptr + 1'b1;
				sw_left <= sw_left - 1'b1;
			end
			if (timer != 32'h00000000)
				timer <= timer - 32'h00000001;
			else if (sw_left == {(MEM_AW + 1){1'b0}}) begin
				powered <= 1'b1;
				if (busy) begin
					busy <= 1'b0;
					wel <= 1'b0;
				end
			end

			if (cs_fall && powered) begin
				tot <= 6'h00;
				cnt <= 6'h00;
				sh <= 32'h00000000;
				got_byte <= 1'b0;
				ocnt <= 4'h0;
				if (enh && !busy && !sleep) begin
					// Continuous quad read: opcode is implied, address comes first
					op <= `OP_QUAD_IO_FETCH;
					state <= S_ADDR;
					wid <= `WID_X4;
					plen <= clocks_for(`ADDR_BITS, `WID_X4);
				end else begin
					op <= `OP_NONE;
					state <= S_CMD;
					wid <= `WID_X1;
					plen <= `BYTE_BITS;
				end
			end else if (cs_rise) begin
				state <= S_IDLE;
				wid <= `WID_X1;
				io_oe_n_o <= 4'hF;
				if (state != S_IDLE) begin
					case (op)
						`OP_WRITE_LATCH_SET: if (tot == `TOT_ONE_BYTE) wel <= 1'b1;
						`OP_WRITE_LATCH_CLEAR: if (tot == `TOT_ONE_BYTE) wel <= 1'b0;
						`OP_STATUS_LOAD: begin
							if (tot == `TOT_TWO_BYTES) begin
								stat_hi <= stat_new[7:2];
								busy <= 1'b1;
								timer <= TW_CYC;
							end
						end
						`OP_PAGE_WRITE, `OP_QUAD_PAGE_WRITE: begin
							if (got_byte) begin
								busy <= 1'b1;
								timer <= PP_CYC;
							end
						end
						`OP_SMALL_REGION_CLEAR, `OP_BLOCK_CLEAR: begin
							if (tot == `TOT_FOUR_BYTES) begin
								busy <= 1'b1;
								timer <= (op == `OP_BLOCK_CLEAR) ? BE_CYC : SE_CYC;
								sw_ptr <= maddr & ~er_msk[MEM_AW-1:0];
								sw_left <= er_len;
							end
						end
						`OP_ARRAY_CLEAR_A, `OP_ARRAY_CLEAR_B: begin
							if (tot == `TOT_ONE_BYTE) begin
								busy <= 1'b1;
								timer <= CE_CYC;
								sw_ptr <= {MEM_AW{1'b0}};
								sw_left <= FULL;
							end
						end
						`OP_DEEP_SLEEP_ENTRY: if (tot == `TOT_ONE_BYTE) sleep <= 1'b1;
						`OP_SLEEP_WAKE: sleep <= 1'b0;
						default: ;
					endcase
				end
			end else if (rise && state != S_IDLE) begin
				sh <= next_sh;
				tot <= (tot == `TOT_MAX) ? tot : tot + 6'h01;
				cnt <= phase_end ? 6'h00 : cnt + 6'h01;
				if (phase_end) begin
					case (state)
						S_CMD: begin
							op <= refuse ? `OP_NONE : op_in;
							if (refuse)
								state <= S_SKIP;
							else begin
								case (op_in)
									`OP_IDENT_BYTES_READ, `OP_STATUS_FETCH: begin
										state <= S_DOUT;
										addr <= 24'h000000;
									end
									`OP_STATUS_LOAD: begin
										state <= S_DIN;
										plen <= `BYTE_BITS;
									end
									`OP_SLEEP_WAKE: begin
										state <= S_DUMMY;
										plen <= `SIG_DUMMY;
									end
									`OP_SINGLE_FETCH, `OP_FAST_FETCH, `OP_PAGE_WRITE,
									`OP_SMALL_REGION_CLEAR, `OP_BLOCK_CLEAR,
									`OP_MAKER_PART_ID_A, `OP_MAKER_PART_ID_B,
									`OP_MAKER_PART_ID_C: begin
										state <= S_ADDR;
										plen <= `ADDR_BITS;
									end
									`OP_DUAL_IO_FETCH: begin
										state <= S_ADDR;
										wid <= `WID_X2;
										plen <= clocks_for(`ADDR_BITS, `WID_X2);
									end
									`OP_QUAD_IO_FETCH, `OP_QUAD_PAGE_WRITE: begin
										state <= S_ADDR;
										wid <= `WID_X4;
										plen <= clocks_for(`ADDR_BITS, `WID_X4);
									end
									default: state <= S_SKIP;
								endcase
							end
						end
						S_ADDR: begin
							addr <= next_sh[23:0];
							case (op)
								`OP_SINGLE_FETCH: state <= S_DOUT;
								`OP_FAST_FETCH: begin
									state <= S_DUMMY;
									plen <= `FAST_DUMMY;
								end
								`OP_DUAL_IO_FETCH: begin
									// Mode bits ride in the dual dummy clocks and are not interpreted
									state <= S_DUMMY;
									plen <= `DUAL_DUMMY;
								end
								`OP_QUAD_IO_FETCH: begin
									state <= S_MODE;
									plen <= `QUAD_MODE;
								end
								`OP_PAGE_WRITE, `OP_QUAD_PAGE_WRITE: begin
									state <= S_DIN;
									plen <= clocks_for(`BYTE_BITS, wid);
								end
								`OP_MAKER_PART_ID_A, `OP_MAKER_PART_ID_B, `OP_MAKER_PART_ID_C: begin
									state <= S_DOUT;
									addr <= {23'h000000, next_sh[0]};
								end
								default: state <= S_SKIP;
							endcase
						end
						S_MODE: begin
							// Only a fully toggled pattern keeps the next frame in continuous mode
							enh <= (next_sh[7:4] ^ next_sh[3:0]) == 4'hF;
							state <= S_DUMMY;
							plen <= `QUAD_DUMMY;
						end
						S_DUMMY: state <= S_DOUT;
						S_DIN: begin
							if (op == `OP_STATUS_LOAD) begin
								stat_new <= next_sh[7:0];
								state <= S_SKIP;
							end else begin
								// Programming only pulls bits low; address wraps inside the page
								mem[maddr] <= mem[maddr] & next_sh[7:0];
								addr <= {addr[23:8], addr[7:0] + 8'h01};
								got_byte <= 1'b1;
							end
						end
						default: ;
					endcase
				end
			end else if (fall && state == S_DOUT) begin
				case (wid)
					`WID_X4: begin
						io_o <= out_src[7:4];
						io_oe_n_o <= 4'h0;
						obuf <= {out_src[3:0], 4'h0};
					end
					`WID_X2: begin
						io_o <= {2'b00, out_src[7:6]};
						io_oe_n_o <= 4'hC;
						obuf <= {out_src[5:0], 2'b00};
					end
					default: begin
						io_o <= {2'b00, out_src[7], 1'b0};
						io_oe_n_o <= 4'hD;
						obuf <= {out_src[6:0], 1'b0};
					end
				endcase
				ocnt <= (ocnt_next == `BYTE_BITS) ? 4'h0 : ocnt_next;
				if (ocnt == 4'h0) begin
					if (op == `OP_IDENT_BYTES_READ && addr[1:0] == 2'h2)
						addr <= 24'h000000;
					else
						addr <= addr + 24'h000001;
				end
			end
		end
	end

endmodule // serial_nor_command_decoder
`default_nettype wire

// ===== design/serial_nor_map.vh
// Opcodes, status layout, phase lengths and timing figures of the serial NOR command decoder
`ifndef SERIAL_NOR_MAP_VH
`define SERIAL_NOR_MAP_VH

`define OP_NONE 8'h00
`define OP_WRITE_LATCH_SET 8'h06
`define OP_WRITE_LATCH_CLEAR 8'h04
`define OP_IDENT_BYTES_READ 8'h9F
`define OP_STATUS_FETCH 8'h05
`define OP_STATUS_LOAD 8'h01
`define OP_SINGLE_FETCH 8'h03
`define OP_FAST_FETCH 8'h0B
`define OP_DUAL_IO_FETCH 8'hBB
`define OP_QUAD_IO_FETCH 8'hEB
`define OP_PAGE_WRITE 8'h02
`define OP_QUAD_PAGE_WRITE 8'h38
`define OP_SMALL_REGION_CLEAR 8'h20
`define OP_BLOCK_CLEAR 8'hD8
`define OP_ARRAY_CLEAR_A 8'h60
`define OP_ARRAY_CLEAR_B 8'hC7
`define OP_DEEP_SLEEP_ENTRY 8'hB9
`define OP_SLEEP_WAKE 8'hAB
`define OP_MAKER_PART_ID_A 8'h90
`define OP_MAKER_PART_ID_B 8'hEF
`define OP_MAKER_PART_ID_C 8'hDF

// Status register: bit 0 busy, bit 1 write latch, bits 7..2 software bits
`define ST_BUSY 0
`define ST_WEL 1
`define STATUS_RESET 8'h00
`define ERASED_BYTE 8'hFF

// Line widths
`define WID_X1 3'h1
`define WID_X2 3'h2
`define WID_X4 3'h4

// Phase lengths in bits or clocks
`define BYTE_BITS 6'h08
`define ADDR_BITS 6'h18
`define FAST_DUMMY 6'h08
`define DUAL_DUMMY 6'h04
`define QUAD_MODE 6'h02
`define QUAD_DUMMY 6'h04
`define SIG_DUMMY 6'h18
`define TOT_ONE_BYTE 6'h08
`define TOT_TWO_BYTES 6'h10
`define TOT_FOUR_BYTES 6'h20
`define TOT_MAX 6'h3F

// Timing figures in microseconds and the clock rate in MHz
`define MCLK_MHZ 25
`define POWERUP_SELECT_DELAY_US 200
`define PAGE_WRITE_TYP_US 600
`define STATUS_LOAD_TYP_US 40000
`define SMALL_REGION_TYP_US 40000
`define BLOCK_TYP_US 400000
`define ARRAY_TYP_US 5000000

`endif

// ===== tb/serial_nor_sva.sv
// Pin-level checker for the serial NOR command decoder
`timescale 1ns/100ps
`default_nettype none
module serial_nor_sva #(
	parameter MEM_AW = 12,
	parameter [31:0] VSL_CYC = 5000
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic [3:0] io_o,
	input wire logic [3:0] io_oe_n_o
);
	localparam int LIM = (2 ** MEM_AW > VSL_CYC) ? 2 ** MEM_AW : VSL_CYC;
	logic [3:0] sh;
	int cnt;
	always_ff @(posedge mclk_i) begin
		sh <= {sh[2:0], sclk_i};
		cnt <= !reset_n_i ? 0 : ((cnt < LIM) ? cnt + 1 : cnt);
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);
	// Pins pass two flops, so a clock fall shows at the outputs three edges later
	sequence s_late_fall;
		sh[3] && !sh[2];
	endsequence
	sequence s_idle;
		cs_n_i [*4];
	endsequence
	a_reset_quiet: assert property ($rose(reset_n_i) |-> io_oe_n_o == 4'hF)
		else $error("pins driven after reset");
	a_powerup_quiet: assert property (cnt < LIM |-> io_oe_n_o == 4'hF)
		else $error("pins driven during power-up");
	a_width_legal: assert property (io_oe_n_o inside {4'hF, 4'hD, 4'hC, 4'h0})
		else $error("bad enable set");
	a_select_needed: assert property (io_oe_n_o != 4'hF |-> $past(cs_n_i, 3) == 1'b0)
		else $error("driven without select");
	a_idle_release: assert property (s_idle |-> io_oe_n_o == 4'hF)
		else $error("driven after deselect");
	a_data_on_fall: assert property (io_oe_n_o != 4'hF && !$stable(io_o) |-> s_late_fall)
		else $error("data moved off a fall");
	a_drive_on_fall: assert property ($rose(io_oe_n_o != 4'hF) |-> s_late_fall)
		else $error("drive began off a fall");
	a_hold_high: assert property (sclk_i && $past(sclk_i) |-> $stable({io_o, io_oe_n_o}))
		else $error("output moved while clock high");
endmodule // serial_nor_sva
bind serial_nor_command_decoder serial_nor_sva #(.MEM_AW(MEM_AW), .VSL_CYC(VSL_CYC))
	serial_nor_sva_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i),
	.sclk_i(sclk_i), .io_o(io_o), .io_oe_n_o(io_oe_n_o));
`default_nettype wire

// ===== tb/host_spi_model.sv
// Host serial controller model: select, mode 0 serial clock and data lines
`timescale 1ns/100ps
`default_nettype none
module host_spi_model (
	input wire logic mclk_i,
	input wire logic [3:0] lines_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic [3:0] hd_o,
	output logic [3:0] hen_o
);
	logic [63:0] rx;
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		hd_o = 4'h0;
		hen_o = 4'h0;
		rx = 64'h0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// Clock stands low outside frames
	task automatic sel();
		wt(1);
		cs_n_o = 1'b0;
		rx = 64'h0;
	endtask
	task automatic desel();
		wt(4);
		cs_n_o = 1'b1;
		hen_o = 4'h0;
		wt(8);
	endtask
	// n clocks of w lines, MSB first; with drv low the lines float
	task automatic ph(input logic [31:0] d, input int n, w, input bit drv);
		for (int i = n - 1; i >= 0; i--) begin
			hen_o = drv ? 4'hF >> (4 - w) : 4'h0;
			for (int b = 0; b < w; b++)
				hd_o[b] = d[i * w + b];
			wt(4);
			sclk_o = 1'b1;
			rx = (w == 1) ? {rx[62:0], lines_i[1]} : (rx << w) | 64'(lines_i & ~(4'hF << w));
			wt(4);
			sclk_o = 1'b0;
		end
	endtask
endmodule // host_spi_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the serial NOR command decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic tog = 1'b0;
	logic seen = 1'b0;
	logic cs_n, sclk;
	logic [3:0] hd, hen, lines, io_o, io_oe_n_o;
	logic [31:0] q;
	int error_cnt = 0;
	int compares = 0;
	initial begin
		forever #20 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		tog <= ~tog;
		if (io_oe_n_o !== 4'hF)
			seen <= 1'b1;
	end
	// A floating line toggles so stale data cannot pass
	always_comb
		for (int b = 0; b < 4; b++)
			lines[b] = (io_oe_n_o[b] === 1'b0) ? io_o[b] : (hen[b] ? hd[b] : tog);
	host_spi_model host (.mclk_i(mclk_i), .lines_i(lines), .cs_n_o(cs_n), .sclk_o(sclk),
		.hd_o(hd), .hen_o(hen));
	serial_nor_command_decoder #(.PP_CYC(20), .TW_CYC(20),
		.SE_CYC(40), .BE_CYC(40), .CE_CYC(40)) serial_nor_command_decoder_inst (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .sclk_i(sclk),
		.io_i(lines), .io_o(io_o), .io_oe_n_o(io_oe_n_o));
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic send(input [7:0] op, input [31:0] d, input int n, w);
		cmd_go: begin
			host.sel();
			host.ph(op, 8, 1, 1);
			if (n > 0)
				host.ph(d, n, w, 1);
			host.desel();
		end
	endtask
	task automatic rd(input [7:0] op, input [23:0] a, input int na, w, nb);
		host.sel();
		host.ph(op, 8, 1, 1);
		if (na > 0)
			host.ph(a, na, w, 1);
		if (op == 8'h0B)
			host.ph(0, 8, 1, 0);
		if (op == 8'hBB) begin
			host.ph(0, 2, 2, 1);
			host.ph(0, 2, 2, 0);
		end
		if (op == 8'hEB) begin
			host.ph(0, 2, 4, 1);
			host.ph(0, 4, 4, 0);
		end
		host.rx = 64'h0;
		host.ph(0, nb * 8 / w, w, 0);
		q = host.rx[31:0];
		host.desel();
	endtask
	// Busy must clear well inside the bound, else the count runs out
	task automatic poll();
		for (int k = 0; k < 40; k++) begin
			rd(8'h05, 0, 0, 1, 1);
			if (q[0] === 1'b0)
				break;
		end
		chk("busy", 32'h0, q[0]);
	endtask
	task automatic pgm(input [7:0] op, input [23:0] a, input [31:0] d, input int nb, w);
		send(8'h06, 0, 0, 1);
		host.sel();
		host.ph(op, 8, 1, 1);
		host.ph(a, 24 / w, w, 1);
		host.ph(d, nb * 8 / w, w, 1);
		host.desel();
		poll();
	endtask
	task automatic t_start();
		rd(8'h05, 0, 0, 1, 2);
		chk("status", 32'h0, q);
		rd(8'h03, 24'h3E, 24, 1, 4);
		chk("array", 32'hFFFFFFFF, q);
		rd(8'h9F, 0, 0, 1, 4);
		chk("ident", 32'h5A21155A, q);
	endtask
	task automatic t_latch();
		send(8'h06, 0, 0, 1);
		rd(8'h05, 0, 0, 1, 1);
		chk("latch set", 32'h02, q);
		send(8'h04, 0, 0, 1);
		rd(8'h05, 0, 0, 1, 1);
		chk("latch clear", 32'h00, q);
	endtask
	task automatic t_reads();
		logic [7:0] ops [4] = '{8'h03, 8'h0B, 8'hBB, 8'hEB};
		int ws [4] = '{1, 1, 2, 4};
		pgm(8'h02, 24'h10, 32'hA53C, 2, 1);
		for (int k = 0; k < 4; k++) begin
			rd(ops[k], 24'h10, 24 / ws[k], ws[k], 2);
			chk("read", 32'hA53C, q);
		end
		pgm(8'h38, 24'h20, 32'h96, 1, 4);
		rd(8'h03, 24'h20, 24, 1, 1);
		chk("quad program", 32'h96, q);
	endtask
	// Toggled mode bits keep the next frame in continuous mode; plain ones end it
	task automatic t_quad_cont();
		host.sel();
		host.ph(8'hEB, 8, 1, 1);
		host.ph(24'h10, 6, 4, 1);
		host.ph(8'h5A, 2, 4, 1);
		host.ph(0, 4, 4, 0);
		host.rx = 64'h0;
		host.ph(0, 2, 4, 0);
		chk("quad first", 32'hA5, host.rx[31:0]);
		host.desel();
		host.sel();
		host.ph(24'h11, 6, 4, 1);
		host.ph(8'h00, 2, 4, 1);
		host.ph(0, 4, 4, 0);
		host.rx = 64'h0;
		host.ph(0, 2, 4, 0);
		chk("quad continued", 32'h3C, host.rx[31:0]);
		host.desel();
		rd(8'h03, 24'h10, 24, 1, 1);
		chk("continuous ended", 32'hA5, q);
	endtask
	task automatic t_erase();
		logic [7:0] ops [4] = '{8'h20, 8'hD8, 8'h60, 8'hC7};
		for (int k = 0; k < 4; k++) begin
			pgm(8'h02, 24'h30, 32'h00, 1, 1);
			rd(8'h03, 24'h30, 24, 1, 1);
			chk("programmed", 32'h00, q);
			send(8'h06, 0, 0, 1);
			send(ops[k], 24'h30, (k < 2) ? 24 : 0, 1);
			poll();
			rd(8'h03, 24'h30, 24, 1, 1);
			chk("erased", 32'hFF, q);
		end
	endtask
	task automatic t_sleep_ids();
		logic [7:0] ops [3] = '{8'h90, 8'hEF, 8'hDF};
		send(8'hB9, 0, 0, 1);
		seen = 1'b0;
		rd(8'h05, 0, 0, 1, 1);
		chk("asleep quiet", 32'h0, seen);
		rd(8'hAB, 0, 24, 1, 2);
		chk("signature", 32'h1414, q);
		for (int k = 0; k < 3; k++) begin
			rd(ops[k], 24'h0, 24, 1, 2);
			chk("maker first", 32'h5A14, q);
			rd(ops[k], 24'h1, 24, 1, 2);
			chk("part first", 32'h145A, q);
		end
	endtask
	task automatic t_status_load();
		send(8'h06, 0, 0, 1);
		send(8'h01, 32'hFC, 8, 1);
		poll();
		rd(8'h05, 0, 0, 1, 1);
		chk("status load", 32'hFC, q);
	endtask
	task automatic give_verdict();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#3000000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge mclk_i);
		@(negedge mclk_i);
		reset_n_i = 1'b1;
		repeat (5010) @(negedge mclk_i);
		t_start();
		t_latch();
		t_reads();
		t_quad_cont();
		t_erase();
		t_sleep_ids();
		t_status_load();
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
